// ==== logic/bt_defs.svh ====
`ifndef BT_DEFS_SVH
`define BT_DEFS_SVH

// register byte offsets
`define BT_OFS_COUNT    8'h00
`define BT_OFS_PRELOAD  8'h04
`define BT_OFS_STATUS   8'h08
`define BT_OFS_IEN      8'h0c
`define BT_OFS_CTRL     8'h10

// control field positions
`define BT_CTRL_ENABLE  0
`define BT_CTRL_UP      2
`define BT_CTRL_AUTO    3
`define BT_CTRL_SOFT    4
`define BT_CTRL_START   5
`define BT_CTRL_RELOAD  6
`define BT_CTRL_HALT    7
`define BT_CTRL_PS_LSB  16
`define BT_CTRL_PS_MSB  31

// status / enable field
`define BT_LIMIT_BIT    0

// reset values
`define BT_RST_COUNT    32'h0000_0000
`define BT_RST_PRELOAD  32'h0000_0000
`define BT_RST_CTRL     32'h0000_0000
`define BT_RST_PS       16'h0000

// masks per counter width
`define BT_MASK_16      32'h0000_ffff
`define BT_MASK_32      32'hffff_ffff

// source clock figure and bench clock rate
`define BT_SRC_CLK_MHZ  48
`define BT_PCLK_MHZ     20

`endif

// ==== logic/bt_pkg.sv ====
package bt_pkg;
    typedef logic [31:0] bt_word_t;
    typedef logic [7:0]  bt_addr_t;
    typedef logic [15:0] bt_ps_t;
    typedef enum logic {
        BT_DOWN,
        BT_UP
    } bt_dir_t;
    typedef enum logic [2:0] {
        BT_SEL_COUNT,
        BT_SEL_PRELOAD,
        BT_SEL_STATUS,
        BT_SEL_IEN,
        BT_SEL_CTRL,
        BT_SEL_NONE
    } bt_sel_t;
endpackage : bt_pkg

// ==== logic/bt_timer.sv ====
// The implementer's own choice: the APB register port.
`timescale 1ns/1ps
`include "bt_defs.svh"
// Operation
// - counter width parameter, 16 or 32
// - all logic on one source clock
// - system reset restores all defaults
// - soft reset bit resets all but rdata and rerr
// - timer reset is system OR soft
// - 16-bit limit at FFFF/0 wrap
// - 32-bit limit at FFFF_FFFF/0 wrap
// - interrupt is status gated by enable
// - low-power granted only when inactive
// - sleepable when disabled, stopped or halted
// - software selects count direction
// - one-shot stops, limit held level
// - continuous reloads preload, limit pulses
// - count reads come from snapshot
// - count writable, avoid writing while running
// - reload, halt, start; count resets zero
// - prescaler enable every setting plus one
// - halt freezes count, resets divider
// - reload ignored once one-shot finished
// - status cleared by write, resets zero
module bt_timer #(
    parameter int WIDTH = 32
) (
    input  wire logic           pclk,       // source clock
    input  wire logic           presetn,    // system reset, low
    input  wire logic           psel,       // apb select
    input  wire logic           penable,    // apb enable
    input  wire logic           pwrite,     // apb direction
    input  wire bt_pkg::bt_addr_t paddr,    // apb byte address
    input  wire bt_pkg::bt_word_t pwdata,   // apb write data
    input  wire logic [3:0]     pstrb,      // apb byte strobes
    output logic                pready,     // apb ready
    output bt_pkg::bt_word_t    prdata,     // apb read data
    output logic                pslverr,    // apb error
    input  wire logic           lp_request, // low-power request
    output logic                lp_grant,   // low-power accepted
    output logic                sleep_ok,   // block may sleep
    output logic                limit_irq   // interrupt event
);
    import bt_pkg::*;

    // width mask
    localparam bt_word_t WMASK =
        (WIDTH == 16) ? `BT_MASK_16 : `BT_MASK_32;

    function automatic bt_sel_t decode(
        input bt_addr_t a
    );
        bt_sel_t s;
        s = BT_SEL_NONE;
        case (a)
            `BT_OFS_COUNT: begin
                s = BT_SEL_COUNT;
            end
            `BT_OFS_PRELOAD: begin
                s = BT_SEL_PRELOAD;
            end
            `BT_OFS_STATUS: begin
                s = BT_SEL_STATUS;
            end
            `BT_OFS_IEN: begin
                s = BT_SEL_IEN;
            end
            `BT_OFS_CTRL: begin
                s = BT_SEL_CTRL;
            end
            default: begin
                s = BT_SEL_NONE;
            end
        endcase
        return s;
    endfunction : decode

    function automatic bt_word_t merge(
        input bt_word_t old_v,
        input bt_word_t new_v,
        input logic [3:0] strb
    );
        bt_word_t r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction : merge

    // drop count bits above the instance width
    function automatic bt_word_t clip(
        input bt_word_t v
    );
        return v & WMASK;
    endfunction : clip

    // access-phase write aimed at one register
    function automatic logic hit(
        input logic    w,
        input bt_sel_t s,
        input bt_sel_t target
    );
        return w && (s == target);
    endfunction : hit

    // state
    bt_word_t count;
    bt_word_t preload;
    bt_word_t snap;
    bt_word_t ctrl;
    logic     status;
    logic     ien;
    logic     soft_rst;
    bt_ps_t   div;
    bt_word_t rdata;
    logic     rerr;

    bt_word_t next_count;
    bt_word_t next_preload;
    bt_word_t next_snap;
    bt_word_t next_ctrl;
    logic     next_status;
    logic     next_ien;
    logic     next_soft_rst;
    bt_ps_t   next_div;
    bt_word_t next_rdata;
    logic     next_rerr;

    // bus decode
    bt_sel_t  sel;
    logic     setup;
    logic     wr;
    bt_word_t wmerged;

    // control fields
    logic     en_bit;
    logic     up_bit;
    logic     auto_bit;
    logic     start_bit;
    logic     halt_bit;
    bt_ps_t   ps;

    // counting
    logic     running;
    logic     tick;
    logic     at_limit;
    logic     limit;
    logic     reload_req;

    // per-register write strobes
    logic     wr_count;
    logic     wr_preload;
    logic     wr_status;
    logic     wr_ien;
    logic     wr_ctrl;

    assign sel     = decode(paddr);
    assign setup   = psel && !penable;
    assign wr      = psel && penable && pwrite;
    assign wr_count   = hit(wr, sel, BT_SEL_COUNT);
    assign wr_preload = hit(wr, sel, BT_SEL_PRELOAD);
    assign wr_status  = hit(wr, sel, BT_SEL_STATUS);
    assign wr_ien     = hit(wr, sel, BT_SEL_IEN);
    assign wr_ctrl    = hit(wr, sel, BT_SEL_CTRL);
    assign en_bit    = ctrl[`BT_CTRL_ENABLE];
    assign up_bit    = ctrl[`BT_CTRL_UP];
    assign auto_bit  = ctrl[`BT_CTRL_AUTO];
    assign start_bit = ctrl[`BT_CTRL_START];
    assign halt_bit  = ctrl[`BT_CTRL_HALT];
    assign ps        = ctrl[`BT_CTRL_PS_MSB:`BT_CTRL_PS_LSB];

    always_comb begin
        wmerged = bt_word_t'(0);
        case (sel)
            BT_SEL_COUNT: begin
                wmerged = merge(count, pwdata, pstrb);
            end
            BT_SEL_PRELOAD: begin
                wmerged = merge(preload, pwdata, pstrb);
            end
            BT_SEL_CTRL: begin
                wmerged = merge(ctrl, pwdata, pstrb);
            end
            default: begin
                wmerged = merge(bt_word_t'(0), pwdata, pstrb);
            end
        endcase
    end

    // prescaler and limit detect
    assign running = en_bit && start_bit && !halt_bit;
    assign tick    = running && (div == ps);
    assign at_limit = up_bit ? (count == WMASK)
                             : (count == bt_word_t'(0));
    assign limit   = tick && at_limit;
    assign reload_req = wr_ctrl
                        && wmerged[`BT_CTRL_RELOAD]
                        && start_bit;

    always_comb begin
        next_div = div;
        if (!running) begin
            next_div = `BT_RST_PS;
        end else if (div == ps) begin
            next_div = `BT_RST_PS;
        end else begin
            next_div = div + 16'h0001;
        end
        if (soft_rst) begin
            next_div = `BT_RST_PS;
        end
    end

    // counter register
    always_comb begin
        next_count = count;
        if (wr_count) begin
            next_count = clip(wmerged);
        end else if (reload_req) begin
            next_count = clip(preload);
        end else if (limit && auto_bit) begin
            next_count = clip(preload);
        end else if (tick) begin
            if (up_bit) begin
                next_count = clip(count + 32'h1);
            end else begin
                next_count = clip(count - 32'h1);
            end
        end
        if (soft_rst) begin
            next_count = `BT_RST_COUNT;
        end
    end

    // preload register
    always_comb begin
        next_preload = preload;
        if (wr_preload) begin
            next_preload = clip(wmerged);
        end
        if (soft_rst) begin
            next_preload = `BT_RST_PRELOAD;
        end
    end

    // control register, start cleared at one-shot limit
    always_comb begin
        next_ctrl = ctrl;
        if (wr_ctrl) begin
            next_ctrl = wmerged;
            next_ctrl[15:8] = 8'h00;
            next_ctrl[1] = 1'b0;
            next_ctrl[`BT_CTRL_SOFT] = 1'b0;
            next_ctrl[`BT_CTRL_RELOAD] = 1'b0;
        end
        if (limit && !auto_bit) begin
            next_ctrl[`BT_CTRL_START] = 1'b0;
        end
        if (soft_rst) begin
            next_ctrl = `BT_RST_CTRL;
        end
    end

    // soft reset strobe, one cycle
    always_comb begin
        next_soft_rst = wr_ctrl
                        && wmerged[`BT_CTRL_SOFT]
                        && !soft_rst;
    end

    // limit status: level in one-shot, pulse in continuous
    always_comb begin
        next_status = status;
        if (auto_bit) begin
            next_status = 1'b0;
        end else if (wr_status
                     && pstrb[0] && pwdata[`BT_LIMIT_BIT]) begin
            next_status = 1'b0;
        end
        if (limit) begin
            next_status = 1'b1;
        end
        if (soft_rst) begin
            next_status = 1'b0;
        end
    end

    // interrupt enable
    always_comb begin
        next_ien = ien;
        if (wr_ien && pstrb[0]) begin
            next_ien = pwdata[`BT_LIMIT_BIT];
        end
        if (soft_rst) begin
            next_ien = 1'b0;
        end
    end

    // read path, snapshot taken in setup phase
    always_comb begin
        next_snap  = snap;
        next_rdata = rdata;
        next_rerr  = 1'b0;
        if (setup) begin
            next_rerr = (sel == BT_SEL_NONE);
            if (sel == BT_SEL_COUNT) begin
                next_snap = clip(count);
            end
            case (sel)
                BT_SEL_COUNT: begin
                    next_rdata = clip(count);
                end
                BT_SEL_PRELOAD: begin
                    next_rdata = clip(preload);
                end
                BT_SEL_STATUS: begin
                    next_rdata = {31'h0, status};
                end
                BT_SEL_IEN: begin
                    next_rdata = {31'h0, ien};
                end
                BT_SEL_CTRL: begin
                    next_rdata = ctrl;
                end
                default: begin
                    next_rdata = bt_word_t'(0);
                end
            endcase
        end else if (psel && sel == BT_SEL_COUNT) begin
            next_rdata = snap;
        end
        if (soft_rst) begin
            next_snap  = `BT_RST_COUNT;
        end
    end

    // registers: async system reset, sync soft reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count    <= `BT_RST_COUNT;
            preload  <= `BT_RST_PRELOAD;
            snap     <= `BT_RST_COUNT;
            ctrl     <= `BT_RST_CTRL;
            status   <= 1'b0;
            ien      <= 1'b0;
            soft_rst <= 1'b0;
            div      <= `BT_RST_PS;
            rdata    <= 32'h0000_0000;
            rerr     <= 1'b0;
        end else begin
            count    <= next_count;
            preload  <= next_preload;
            snap     <= next_snap;
            ctrl     <= next_ctrl;
            status   <= next_status;
            ien      <= next_ien;
            soft_rst <= next_soft_rst;
            div      <= next_div;
            rdata    <= next_rdata;
            rerr     <= next_rerr;
        end
    end

    // outputs
    assign pready    = 1'b1;
    assign prdata    = rdata;
    assign pslverr   = psel && penable && rerr;
    assign limit_irq = status && ien;
    assign sleep_ok  = !en_bit || !start_bit || halt_bit;
    assign lp_grant  = lp_request && !start_bit;

endmodule : bt_timer

// ==== tb/bt_timer_sva.sv ====
`timescale 1ns/1ps
module bt_timer_sva #(
    parameter int WIDTH = 32
) (
    input wire logic             pclk,       // clock
    input wire logic             presetn,    // reset
    input wire logic             psel,       // select
    input wire logic             penable,    // enable
    input wire logic             pwrite,     // write
    input wire bt_pkg::bt_addr_t paddr,      // address
    input wire bt_pkg::bt_word_t pwdata,     // wdata
    input wire logic [3:0]       pstrb,      // strobes
    input wire logic             pready,     // ready
    input wire bt_pkg::bt_word_t prdata,     // rdata
    input wire logic             pslverr,    // error
    input wire logic             lp_request, // lp ask
    input wire logic             lp_grant,   // lp ok
    input wire logic             sleep_ok,   // sleepable
    input wire logic             limit_irq   // irq
);
    import bt_pkg::*;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic rd, wr;
    assign rd = psel && penable && !pwrite;
    assign wr = psel && penable && pwrite && pstrb[0];
    property p_rst; $rose(presetn) |-> sleep_ok && !limit_irq; endproperty
    a_rst: assert property (p_rst) else $error("state after reset");
    property p_grant; lp_grant |-> lp_request; endproperty
    a_grant: assert property (p_grant) else $error("grant unasked");
    property p_busy; !sleep_ok |-> !lp_grant; endproperty
    a_busy: assert property (p_busy) else $error("grant while active");
    property p_unmap; rd && paddr > 8'h10 |-> pslverr && prdata == '0; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read");
    property p_ctl; rd && paddr == 8'h10 |-> prdata[15:8] == '0 && prdata[6] == 1'b0; endproperty
    a_ctl: assert property (p_ctl) else $error("control spare bits");
    property p_flag; rd && paddr inside {8'h08, 8'h0c} |-> prdata[31:1] == '0; endproperty
    a_flag: assert property (p_flag) else $error("flag spare bits");
    property p_wide; WIDTH == 16 && rd && paddr == 8'h00 |-> prdata[31:16] == '0; endproperty
    a_wide: assert property (p_wide) else $error("count upper bits");
    property p_ien; wr && paddr == 8'h0c && !pwdata[0] |=> !limit_irq; endproperty
    a_ien: assert property (p_ien) else $error("irq while disabled");
    property p_soft; wr && paddr == 8'h10 && pwdata[4] |-> ##3 (sleep_ok && !limit_irq);
    endproperty
    a_soft: assert property (p_soft) else $error("soft reset");
    c_irq: cover property ($rose(limit_irq));
    c_err: cover property (pslverr);
    c_lp: cover property (lp_grant);
endmodule : bt_timer_sva

bind bt_timer bt_timer_sva #(.WIDTH(WIDTH)) u_sva (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .lp_request(lp_request), .lp_grant(lp_grant), .sleep_ok(sleep_ok),
    .limit_irq(limit_irq));

// ==== tb/bt_timer_tb.sv ====
`timescale 1ns/1ps
module bt_timer_tb;
    import bt_pkg::*;
    logic       pclk, presetn, psel, penable, pwrite, lp_request;
    logic       pready, pslverr, lp_grant, sleep_ok, limit_irq, err;
    logic [3:0] pstrb;
    bt_addr_t   paddr;
    bt_word_t   pwdata, prdata, v, w;
    int         fail_count, tests_run, c;

    bt_timer #(.WIDTH(16)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .lp_request(lp_request), .lp_grant(lp_grant), .sleep_ok(sleep_ok),
        .limit_irq(limit_irq));

    always #25 pclk = ~pclk;

    task automatic chk(input string n, input bt_word_t g, input bt_word_t e);
        tests_run++;
        if (g !== e) begin
            fail_count++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask : chk

    task automatic xfer(input logic wr, input bt_addr_t a, input bt_word_t d);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        v = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : xfer

    task automatic wirq();
        c = 0;
        while (limit_irq !== 1'b1 && c < 300) begin
            @(posedge pclk);
            #1;
            c++;
        end
    endtask : wirq

    task automatic zeros();
        for (int i = 0; i < 5; i++) begin
            xfer(1'b0, 8'(4 * i), '0);
            chk("default", v, '0);
        end
    endtask : zeros

    task automatic finish_test();
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : finish_test

    initial begin
        repeat (5000) @(posedge pclk);
        fail_count++;
        finish_test();
    end

    initial begin
        pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0;
        paddr = '0; pwdata = '0; pstrb = 4'hf; lp_request = 0;
        fail_count = 0; tests_run = 0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        zeros();
        xfer(1'b0, 8'h14, '0);
        chk("slverr", 32'(err), 32'h1);
        chk("unmapped", v, '0);
        xfer(1'b1, 8'h00, 32'h0000_fffe);
        xfer(1'b0, 8'h00, '0);
        chk("count", v, 32'h0000_fffe);
        xfer(1'b1, 8'h0c, 32'h1);
        // one-shot, up, full rate
        xfer(1'b1, 8'h10, 32'h25);
        wirq();
        chk("irq", 32'(limit_irq), 32'h1);
        chk("sleep", 32'(sleep_ok), 32'h1);
        xfer(1'b0, 8'h00, '0);
        chk("wrapped", v, '0);
        xfer(1'b0, 8'h10, '0);
        chk("ctrl", v, 32'h5);
        xfer(1'b0, 8'h08, '0);
        chk("status", v, 32'h1);
        xfer(1'b1, 8'h08, 32'h1);
        xfer(1'b0, 8'h08, '0);
        chk("cleared", v, '0);
        chk("irq low", 32'(limit_irq), '0);
        // reload refused once the one-shot run is over
        xfer(1'b1, 8'h04, 32'h7);
        xfer(1'b1, 8'h10, 32'h45);
        xfer(1'b0, 8'h00, '0);
        chk("no reload", v, '0);
        // continuous, down, prescale 3
        lp_request <= 1'b1;
        xfer(1'b1, 8'h04, 32'h5);
        xfer(1'b1, 8'h00, 32'h1);
        xfer(1'b1, 8'h10, 32'h0003_0029);
        wirq();
        chk("grant", 32'(lp_grant), '0);
        chk("busy", 32'(sleep_ok), '0);
        @(posedge pclk);
        #1;
        chk("pulse", 32'(limit_irq), '0);
        wirq();
        chk("period", 32'(c), 32'(6 * 4 - 1));
        xfer(1'b0, 8'h00, '0);
        chk("restart", v, 32'h5);
        xfer(1'b1, 8'h10, 32'h0003_00a9);
        #1;
        chk("halt sleep", 32'(sleep_ok), 32'h1);
        xfer(1'b0, 8'h00, '0);
        w = v;
        repeat (12) @(posedge pclk);
        xfer(1'b0, 8'h00, '0);
        chk("frozen", v, w);
        xfer(1'b1, 8'h04, 32'h0abc);
        xfer(1'b1, 8'h10, 32'h0003_00e9);
        xfer(1'b0, 8'h00, '0);
        chk("reload", v, 32'h0abc);
        xfer(1'b1, 8'h0c, '0);
        xfer(1'b1, 8'h10, 32'h10);
        repeat (3) @(posedge pclk);
        zeros();
        chk("idle grant", 32'(lp_grant), 32'h1);
        // one-shot down wrap, then system reset after the run has stopped
        xfer(1'b1, 8'h0c, 32'h1);
        xfer(1'b1, 8'h04, 32'h0000_1111);
        xfer(1'b1, 8'h10, 32'h21);
        xfer(1'b0, 8'h00, '0);
        chk("down wrap", v, 32'h0000_ffff);
        chk("irq down", 32'(limit_irq), 32'h1);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        zeros();
        finish_test();
    end
endmodule : bt_timer_tb
